// ===== core/cbi_host_ctrl.sv
// host-side glue between an 8-bit processor bus and bus-compatible adc/dac converters
// Summary of operation
// - adc output enable is high only during a qualified read of the adc address
// - converter controls assert only on their address during a valid bus cycle; here the start strobe is timed from the converter clock, not the bus cycle
// - conversion done may feed the host interrupt directly
// - dac latch enable is a low pulse from write strobe and dac address
// - decoded addresses are gated with the valid-cycle qualifier and phase-two clock
// - one adc address: write starts a conversion, read enables its outputs
// - start strobe leads the next falling converter clock by at least 1.5 us
// - start strobe trailing edge stays 200 ns away from any falling clock edge
// - conversion ends under ten converter clocks after the strobe ends
// - up to five adc done outputs may be wire-anded into one line
// - converter clock near 600 kHz for full accuracy
// - dac latch enable is delayed until write data is stable
// - adc clock may come from the host clock, easing start timing
`timescale 1ns/1ns
module cbi_host_ctrl
  import cbi_pkg::*;
#(
  parameter logic [15:0] ADC_BASE = cbi_pkg::ADC_ADDR,
  parameter logic [15:0] DAC_BASE = cbi_pkg::DAC_ADDR,
  parameter int N_ADC = cbi_pkg::NUM_ADC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] host_addr,
  input wire logic host_rd_wr,
  input wire logic valid_memory_cycle,
  input wire logic host_phi2,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rdata_oe,
  output logic host_ready,
  output logic host_irq_n,
  output logic conv_clk,
  output logic conversion_start_strobe_n,
  output logic adc_oe,
  input wire logic [7:0] adc_data,
  input wire logic conversion_done_flag,
  output logic dac_latch_en_n,
  output logic [7:0] dac_data,
  output logic dac_data_oe,
  output logic conv_busy
);
  import cbi_pkg::*;

  typedef enum {ST_IDLE, ST_ARM, ST_LOW, ST_WAIT_DONE} cbi_start_t;
  typedef enum {DS_IDLE, DS_SETTLE, DS_LOW, DS_REL} cbi_dac_t;

  logic [7:0] phase;
  logic fall_pulse;
  logic adc_sel, dac_sel, qual, adc_rd, adc_wr, dac_wr;
  logic start_ok, end_ok;
  cbi_start_t st_q, st_d;
  cbi_dac_t ds_q, ds_d;
  logic [3:0] fall_cnt_q, fall_cnt_d;
  logic [7:0] dcnt_q, dcnt_d;
  logic [7:0] dac_q, dac_d;
  logic wr_seen_q, wr_seen_d;
  logic done_seen_q, done_seen_d;
  logic adc_wr_q, adc_wr_d, wr_rise;

  // converter clock taken from the core clock so strobe edges can be placed exactly
  cbi_clkdiv #(.DIV(CONV_DIV)) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .conv_clk(conv_clk),
    .phase(phase),
    .fall_pulse(fall_pulse)
  );

  // address decode qualified by valid cycle and phase two
  assign qual = valid_memory_cycle & host_phi2;
  assign adc_sel = (host_addr == ADC_BASE);
  assign dac_sel = (host_addr == DAC_BASE);
  assign adc_rd = qual & adc_sel & host_rd_wr;
  assign adc_wr = qual & adc_sel & ~host_rd_wr;
  assign dac_wr = qual & dac_sel & ~host_rd_wr;

  // adc output buffers enabled only during the qualified read itself
  assign adc_oe = adc_rd;
  assign host_rdata = adc_data;
  assign host_rdata_oe = adc_rd;

  // the strobe falls one core clock after a converter clock fall, so the next fall is
  // one period less a core clock away, which covers the lead time at the default divide
  assign start_ok = (phase == 8'(CONV_HALF));
  // a host write cycle spans many core clocks; only its first clock requests a start
  assign wr_rise = adc_wr & ~adc_wr_q;
  // release at the midpoint of the high half, clear of both falling edges
  assign end_ok = (phase == 8'(KEEPOUT_CYC + 1)) && (fall_cnt_q == 4'h1);

  // start strobe sequencer
  always_comb begin
    st_d = st_q;
    fall_cnt_d = fall_cnt_q;
    wr_seen_d = wr_seen_q;
    done_seen_d = done_seen_q;
    adc_wr_d = adc_wr;
    unique case (st_q)
      ST_IDLE: begin
        // one pending start at a time; writes during a conversion merge into one
        if (wr_seen_q) begin
          st_d = ST_ARM;
          wr_seen_d = 1'b0;
        end
      end
      ST_ARM: begin
        // wait for the only phase that leaves the full lead before the next fall
        if (start_ok) begin
          st_d = ST_LOW;
          fall_cnt_d = 4'h0;
        end
      end
      ST_LOW: begin
        // hold the strobe over one falling edge, then release mid high phase
        if (fall_pulse) begin
          fall_cnt_d = fall_cnt_q + 4'h1;
        end
        if (end_ok) begin
          st_d = ST_WAIT_DONE;
          fall_cnt_d = 4'h0;
          done_seen_d = 1'b0;
        end
      end
      ST_WAIT_DONE: begin
        // done may be shared by several wire-anded adcs, so also time out
        if (fall_pulse) begin
          fall_cnt_d = fall_cnt_q + 4'h1;
        end
        if (!conversion_done_flag) begin
          done_seen_d = 1'b1;
        end
        if ((done_seen_q && conversion_done_flag) || fall_cnt_q == 4'(CONV_CLOCKS)) begin
          st_d = ST_IDLE;
        end
      end
    endcase
    // a fresh write in the cycle of the hand-off must not be lost, so the set wins
    if (wr_rise) begin
      wr_seen_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      fall_cnt_q <= 4'h0;
      wr_seen_q <= 1'b0;
      done_seen_q <= 1'b0;
      adc_wr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      fall_cnt_q <= fall_cnt_d;
      wr_seen_q <= wr_seen_d;
      done_seen_q <= done_seen_d;
      adc_wr_q <= adc_wr_d;
    end
  end

  assign conversion_start_strobe_n = (st_q != ST_LOW);
  assign conv_busy = (st_q != ST_IDLE) | wr_seen_q;
  // wire-anded done line passed straight to the host, active low when busy
  assign host_irq_n = conversion_done_flag;

  // dac write: let the data settle, capture it, then pulse the latch enable low
  always_comb begin
    ds_d = ds_q;
    dcnt_d = dcnt_q;
    dac_d = dac_q;
    unique case (ds_q)
      DS_IDLE: begin
        if (dac_wr) begin
          ds_d = DS_SETTLE;
          dcnt_d = 8'(DATA_SETTLE_CYC);
        end
      end
      DS_SETTLE: begin
        // sample data at the end of the settle wait, not at the decode
        dcnt_d = dcnt_q - 8'h01;
        if (dcnt_q == 8'h01) begin
          dac_d = host_wdata;
          ds_d = DS_LOW;
          dcnt_d = 8'(DAC_LOW_CYC);
        end
      end
      DS_LOW: begin
        dcnt_d = dcnt_q - 8'h01;
        if (dcnt_q == 8'h01) begin
          ds_d = DS_REL;
        end
      end
      DS_REL: begin
        // wait for the host cycle to end so one write gives one pulse
        if (!dac_wr) begin
          ds_d = DS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ds_q <= DS_IDLE;
      dcnt_q <= 8'h00;
      dac_q <= 8'h00;
    end else begin
      ds_q <= ds_d;
      dcnt_q <= dcnt_d;
      dac_q <= dac_d;
    end
  end

  // data is held stable through the whole low pulse so the latch closes on it
  assign dac_latch_en_n = (ds_q != DS_LOW);
  assign dac_data = dac_q;
  assign dac_data_oe = (ds_q == DS_LOW);
  assign host_ready = (ds_q == DS_IDLE);
endmodule

// ===== core/cbi_pkg.sv
// shared constants for the converter bus interface controller
package cbi_pkg;
  // core clock rate in kHz (100 ns period)
  localparam int CORE_CLK_KHZ = 10000;
  // wanted converter clock in kHz, derived by division of the core clock
  localparam int CONV_CLK_KHZ = 625;
  localparam int CONV_DIV = CORE_CLK_KHZ / CONV_CLK_KHZ;
  localparam int CONV_HALF = CONV_DIV / 2;
  // start strobe lead before the first falling converter clock edge, in ns
  localparam int START_LEAD_NS = 1500;
  localparam int START_LEAD_CYC = (START_LEAD_NS * CORE_CLK_KHZ + 999999) / 1000000;
  // keep-out around a falling converter clock edge for the strobe trailing edge, in ns
  localparam int KEEPOUT_NS = 200;
  localparam int KEEPOUT_CYC = (KEEPOUT_NS * CORE_CLK_KHZ + 999999) / 1000000;
  // conversion completes within this many converter clocks after the strobe ends
  localparam int CONV_CLOCKS = 10;
  // host write data settle time before the dac latch enable falls, in ns
  localparam int DATA_SETTLE_NS = 200;
  localparam int DATA_SETTLE_CYC = (DATA_SETTLE_NS * CORE_CLK_KHZ + 999999) / 1000000;
  // dac latch enable low time, in core clocks
  localparam int DAC_LOW_CYC = 3;
  // default address map
  localparam logic [15:0] ADC_ADDR = 16'hC000;
  localparam logic [15:0] DAC_ADDR = 16'hC001;
  localparam int NUM_ADC = 1;
  localparam int MAX_WIRED_ADC = 5;
endpackage

// ===== core/cbi_clkdiv.sv
// converter clock divider with falling-edge phase indication
`timescale 1ns/1ns
module cbi_clkdiv
  import cbi_pkg::*;
#(
  parameter int DIV = cbi_pkg::CONV_DIV
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic conv_clk,
  output logic [7:0] phase,
  output logic fall_pulse
);
  logic [7:0] cnt_q, cnt_d;
  logic clk_q, clk_d;

  // free-running phase counter; clock is high for the first half
  always_comb begin
    cnt_d = (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
    clk_d = (cnt_d < 8'(DIV / 2));
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      clk_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign conv_clk = clk_q;
  assign phase = cnt_q;
  // converter clock falls when the counter reaches the half point
  assign fall_pulse = (cnt_q == 8'(DIV / 2));
endmodule

// ===== tb/cbi_host_ctrl_properties.sv
// timing checker for the converter bus glue
`timescale 1ns/1ns
module cbi_host_ctrl_properties
  import cbi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] host_addr,
  input wire logic host_rd_wr,
  input wire logic valid_memory_cycle,
  input wire logic host_phi2,
  input wire logic [7:0] host_wdata,
  input logic host_rdata_oe,
  input logic host_irq_n,
  input logic conv_clk,
  input logic conversion_start_strobe_n,
  input logic adc_oe,
  input wire logic conversion_done_flag,
  input logic dac_latch_en_n,
  input logic [7:0] dac_data,
  input wire logic dac_data_oe,
  input wire logic host_ready,
  input wire logic conv_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // qualified bus cycles
  wire qv = valid_memory_cycle & host_phi2;
  wire rd_adc = qv & host_rd_wr & (host_addr == ADC_ADDR);
  wire wr_dac = qv & !host_rd_wr & (host_addr == DAC_ADDR);
  sequence s_calm;
    !$fell(conv_clk);
  endsequence
  property p_lead; $fell(conversion_start_strobe_n) |-> s_calm[*8] ##1 s_calm[*7]; endproperty
  a_lead: assert property (p_lead) else $error("start lead short");
  property p_trail; $rose(conversion_start_strobe_n) |-> s_calm[*3]; endproperty
  a_trail: assert property (p_trail) else $error("clock fell near strobe end");
  property p_trail_b; $fell(conv_clk) |-> (!$rose(conversion_start_strobe_n))[*3]; endproperty
  a_trail_b: assert property (p_trail_b) else $error("strobe ended near clock fall");
  property p_oe_only; adc_oe |-> rd_adc; endproperty
  a_oe_only: assert property (p_oe_only) else $error("adc enable off cycle");
  property p_oe_on; rd_adc |-> adc_oe && host_rdata_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("adc read not enabled");
  property p_irq; host_irq_n == conversion_done_flag; endproperty
  a_irq: assert property (p_irq) else $error("irq not done flag");
  property p_dac_gate; !dac_latch_en_n |-> wr_dac && dac_data == host_wdata; endproperty
  a_dac_gate: assert property (p_dac_gate) else $error("latch enable off cycle");
  property p_settle; $fell(dac_latch_en_n) |-> $past(host_wdata, 2) == host_wdata; endproperty
  a_settle: assert property (p_settle) else $error("latch before data settled");
  // the latch must see driven data for the whole time it is open
  property p_dac_drive; !dac_latch_en_n |-> dac_data_oe; endproperty
  a_dac_drive: assert property (p_dac_drive) else $error("dac data not driven");
  // a qualified dac write is taken on its first clock
  property p_dac_take; $rose(wr_dac) |=> !host_ready; endproperty
  a_dac_take: assert property (p_dac_take) else $error("dac write not taken");
  // a start strobe is only ever issued for a pending conversion
  property p_start_busy; !conversion_start_strobe_n |-> conv_busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("strobe while not busy");
endmodule
bind cbi_host_ctrl cbi_host_ctrl_properties cbi_host_ctrl_properties_inst (.core_clk, .rst,
  .host_addr, .host_rd_wr, .valid_memory_cycle, .host_phi2, .host_wdata, .host_rdata_oe,
  .host_irq_n, .conv_clk, .conversion_start_strobe_n, .adc_oe, .conversion_done_flag,
  .dac_latch_en_n, .dac_data, .dac_data_oe, .host_ready, .conv_busy);

// ===== tb/cbi_conv_model.sv
// behavioural adc and latched dac on the far side
`timescale 1ns/1ns
module cbi_conv_model (
  input wire logic conv_clk,
  input wire logic conversion_start_strobe_n,
  input wire logic adc_oe,
  input wire logic [7:0] sample_in,
  output logic [7:0] adc_data,
  output logic conversion_done_flag,
  input wire logic dac_latch_en_n,
  input wire logic [7:0] dac_data,
  output logic [7:0] dac_out
);
  logic [7:0] result_q = 8'h00;
  int edges = 0;
  initial conversion_done_flag = 1'b1;
  initial dac_out = 8'h00;
  // start pulse makes the converter busy and captures the sample
  always @(negedge conversion_start_strobe_n) begin
    conversion_done_flag = 1'b0;
    edges = 0;
    result_q = sample_in;
  end
  // ninth falling clock after the pulse ends the cycle
  always @(negedge conv_clk) begin
    if (!conversion_done_flag && conversion_start_strobe_n) begin
      edges++;
      if (edges == 9) conversion_done_flag = 1'b1;
    end
  end
  // released bus shows the inverse so a stale copy cannot pass
  assign adc_data = adc_oe ? result_q : ~result_q;
  // transparent while enable is low, holds once it returns high
  always @(dac_latch_en_n or dac_data) if (!dac_latch_en_n) dac_out = dac_data;
endmodule

// ===== tb/cbi_host_ctrl_test.sv
// self-checking bench for the converter bus glue
`timescale 1ns/1ns
module cbi_host_ctrl_test;
  import cbi_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] host_addr = 16'h0000;
  logic host_rd_wr = 1'b1;
  logic valid_memory_cycle = 1'b0;
  logic host_phi2 = 1'b0;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] sample_in = 8'h00;
  logic [7:0] host_rdata, adc_data, dac_data, dac_out, d;
  logic host_rdata_oe, host_ready, host_irq_n, conv_clk, conversion_start_strobe_n, adc_oe;
  logic conversion_done_flag, dac_latch_en_n, dac_data_oe, conv_busy;
  logic [31:0] seed = 32'hCFEF;
  int fails = 0;
  int compares = 0;
  int low_cycles = 0;
  logic span_ok;
  // expected conversion results, in the order the starts were issued
  logic [7:0] exp_adc[$];
  always #50 core_clk = ~core_clk;
  cbi_host_ctrl cbi_host_ctrl_inst (.core_clk, .rst, .host_addr, .host_rd_wr,
    .valid_memory_cycle, .host_phi2, .host_wdata, .host_rdata, .host_rdata_oe, .host_ready,
    .host_irq_n, .conv_clk, .conversion_start_strobe_n, .adc_oe, .adc_data,
    .conversion_done_flag, .dac_latch_en_n, .dac_data, .dac_data_oe, .conv_busy);
  cbi_conv_model cbi_conv_model_inst (.conv_clk, .conversion_start_strobe_n, .adc_oe,
    .sample_in, .adc_data, .conversion_done_flag, .dac_latch_en_n, .dac_data, .dac_out);
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  // one host bus cycle held for n+1 clocks; reads are checked before release
  task automatic cyc(input logic [15:0] a, input logic rw, input logic [7:0] v,
                     input logic p2, input int n);
    @(posedge core_clk);
    host_addr <= a;
    host_rd_wr <= rw;
    host_wdata <= v;
    valid_memory_cycle <= 1'b1;
    host_phi2 <= p2;
    repeat (n) @(posedge core_clk);
    #1;
    if (rw) chk(host_rdata, v, "adc read");
    @(posedge core_clk);
    valid_memory_cycle <= 1'b0;
    host_phi2 <= 1'b0;
    host_rd_wr <= 1'b1;
  endtask
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // busy time after the strobe has ended, for the conversion bound
  always @(posedge core_clk) begin
    if (conversion_done_flag === 1'b0 && conversion_start_strobe_n === 1'b1) low_cycles++;
  end
  // about 500 clocks of work; forty times that means a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({7'h00, conversion_start_strobe_n}, 8'h01, "strobe idle");
    chk({7'h00, dac_latch_en_n}, 8'h01, "latch idle");
    chk({7'h00, adc_oe}, 8'h00, "oe idle");
    chk({7'h00, conv_busy}, 8'h00, "busy idle");
    chk({7'h00, host_ready}, 8'h01, "ready idle");
    // dac writes, then a wrong address and an unqualified cycle that must not latch
    repeat (4) begin
      d = xs();
      cyc(DAC_ADDR, 1'b0, d, 1'b1, 8);
      cyc(16'hC002, 1'b0, ~d, 1'b1, 8);
      cyc(DAC_ADDR, 1'b0, d ^ 8'h5A, 1'b0, 8);
      chk(dac_out, d, "dac value");
    end
    // conversions through one address: write starts, read returns the sample
    repeat (2) begin
      sample_in = xs();
      exp_adc.push_back(sample_in);
      low_cycles = 0;
      cyc(ADC_ADDR, 1'b0, xs(), 1'b1, 40);
      #1;
      chk({7'h00, conv_busy}, 8'h01, "busy after start");
      for (int k = 0; k < 300 && conversion_done_flag !== 1'b1; k++) @(posedge core_clk);
      #1;
      // one long host write must give one conversion, so nothing stays pending
      chk({7'h00, conv_busy}, 8'h00, "busy after done");
      span_ok = low_cycles > 8 * CONV_DIV && low_cycles < CONV_CLOCKS * CONV_DIV;
      chk({7'h00, span_ok}, 8'h01, "busy span");
      cyc(ADC_ADDR, 1'b1, exp_adc.pop_front(), 1'b1, 4);
      #1;
      chk({7'h00, adc_oe}, 8'h00, "oe after read");
    end
    end_of_test();
  end
endmodule
